/* hw/acs_cal_seq.sv */
// Calibration sequencer top with Avalon-MM registers and sample pipeline
// Behaviour
// - With trimming on, a calibration ends within 1.62 million cycles.
// - With trimming off, a calibration ends within 1.35 million cycles.
// - Delay select low: at most 2^26 cycles before power-up calibration.
// - Delay select high: at most 2^32 cycles before power-up calibration.
// - A new result every cycle after a fixed pipeline latency.
// - Output data update on the falling clock edge after the latency.
// - Calibrate high at power-up holds off calibration until a valid request.
// - Sleep at power-up stops the delay counter until sleep drops.
// - No calibration starts or runs while asleep.
`timescale 1ns/1ns
module acs_cal_seq #(
  parameter int W = 8,
  parameter logic [32:0] DLY_SHORT_CYC = acs_pkg::ACS_DLY_SHORT,
  parameter logic [32:0] DLY_LONG_CYC = acs_pkg::ACS_DLY_LONG,
  parameter logic [20:0] CAL_TRIM_CYC = acs_pkg::ACS_CAL_TRIM_TYP,
  parameter logic [20:0] CAL_NOTRIM_CYC = acs_pkg::ACS_CAL_NOTRIM_TYP
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cal_pin,
  input wire logic sleep_request,
  input wire logic startup_delay_select,
  input wire logic [W-1:0] adc_sample,
  output logic [W-1:0] adc_data_out,
  output logic cal_busy,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  acs_pkg::acs_state_t state_r, state_nxt;
  logic [2:0] sync1_r, sync2_r;
  logic cal_s, sleep_s, dsel_s;
  logic [1:0] boot_r, boot_nxt;
  logic hold_r, hold_nxt, dsel_r, dsel_nxt, done_r, done_nxt;
  logic [32:0] dly_r, dly_nxt;
  logic [20:0] cnt_r, cnt_nxt, len_r, len_nxt;
  logic [10:0] low_r, low_nxt, high_r, high_nxt;
  logic armed_r, armed_nxt, req_r, req_nxt;
  logic rtrim_r, rtrim_nxt, swcal_r, swcal_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic cal_req, wr_ctrl;

  // Register hit test, used by reads and writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else if (clk_en) begin
      sync1_r <= {startup_delay_select, sleep_request, cal_pin};
      sync2_r <= sync1_r;
    end
  end
  assign cal_s = sync2_r[0];
  assign sleep_s = sync2_r[1];
  assign dsel_s = sync2_r[2];

  ////////////////////////////////////////////////////////////////////////
  // Calibrate pin request detector: long low, then long high
  always_comb begin
    low_nxt = low_r;
    high_nxt = high_r;
    armed_nxt = armed_r;
    req_nxt = 1'b0;
    if (!cal_s) begin
      high_nxt = 11'h000;
      if (low_r != acs_pkg::ACS_CAL_LOW_MIN) begin
        low_nxt = low_r + 11'h001;
      end
      if (low_nxt == acs_pkg::ACS_CAL_LOW_MIN) begin
        armed_nxt = 1'b1;
      end
    end else begin
      low_nxt = 11'h000;
      if (armed_r) begin
        high_nxt = high_r + 11'h001;
        if (high_nxt == acs_pkg::ACS_CAL_HIGH_MIN) begin
          req_nxt = 1'b1;
          armed_nxt = 1'b0;
          high_nxt = 11'h000;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_r <= 11'h000;
      high_r <= 11'h000;
      armed_r <= 1'b0;
      req_r <= 1'b0;
    end else if (clk_en) begin
      low_r <= low_nxt;
      high_r <= high_nxt;
      armed_r <= armed_nxt;
      req_r <= req_nxt;
    end
  end

  assign cal_req = req_r | swcal_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: boot, start-up delay, hold-off, calibrate, idle
  always_comb begin
    state_nxt = state_r;
    boot_nxt = boot_r;
    hold_nxt = hold_r;
    dsel_nxt = dsel_r;
    done_nxt = done_r;
    dly_nxt = dly_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    case (state_r)
      acs_pkg::ACS_S_BOOT: begin
        boot_nxt = boot_r + 2'h1;
        if (boot_r == acs_pkg::ACS_BOOT_CYC) begin
          hold_nxt = cal_s;
          dsel_nxt = dsel_s;
          state_nxt = acs_pkg::ACS_S_DELAY;
        end
      end
      acs_pkg::ACS_S_DELAY: begin
        if (!sleep_s) begin
          dly_nxt = dly_r + 33'h0_0000_0001;
          if (dly_nxt == (dsel_r ? DLY_LONG_CYC : DLY_SHORT_CYC)) begin
            state_nxt = hold_r ? acs_pkg::ACS_S_HOLD : acs_pkg::ACS_S_CAL;
            len_nxt = rtrim_r ? CAL_TRIM_CYC : CAL_NOTRIM_CYC;
            cnt_nxt = 21'h00_0000;
          end
        end
      end
      acs_pkg::ACS_S_HOLD, acs_pkg::ACS_S_IDLE: begin
        if (cal_req && !sleep_s) begin
          state_nxt = acs_pkg::ACS_S_CAL;
          hold_nxt = 1'b0;
          len_nxt = rtrim_r ? CAL_TRIM_CYC : CAL_NOTRIM_CYC;
          cnt_nxt = 21'h00_0000;
        end
      end
      acs_pkg::ACS_S_CAL: begin
        if (!sleep_s) begin
          cnt_nxt = cnt_r + 21'h00_0001;
          if (cnt_nxt == len_r) begin
            state_nxt = acs_pkg::ACS_S_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = acs_pkg::ACS_S_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= acs_pkg::ACS_S_BOOT;
      boot_r <= 2'h0;
      hold_r <= 1'b0;
      dsel_r <= 1'b0;
      done_r <= 1'b0;
      dly_r <= 33'h0_0000_0000;
      cnt_r <= 21'h00_0000;
      len_r <= 21'h00_0000;
    end else if (clk_en) begin
      state_r <= state_nxt;
      boot_r <= boot_nxt;
      hold_r <= hold_nxt;
      dsel_r <= dsel_nxt;
      done_r <= done_nxt;
      dly_r <= dly_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
    end
  end

  // Busy for the whole calibration; requests only taken outside it
  assign cal_busy = (state_r == acs_pkg::ACS_S_CAL);

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ctrl = avs_write & ack_r & hit(avs_address, acs_pkg::ACS_OFF_CTRL) &
                   avs_byteenable[0];

  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rtrim_nxt = rtrim_r;
    swcal_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (wr_ctrl) begin
      rtrim_nxt = avs_writedata[acs_pkg::ACS_CTRL_RTRIM_BIT];
      swcal_nxt = avs_writedata[acs_pkg::ACS_CTRL_SWCAL_BIT];
    end
    if (avs_read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(avs_address, acs_pkg::ACS_OFF_CTRL)) begin
        rdata_nxt[acs_pkg::ACS_CTRL_RTRIM_BIT] = rtrim_r;
      end else if (hit(avs_address, acs_pkg::ACS_OFF_STATUS)) begin
        rdata_nxt[acs_pkg::ACS_ST_BUSY_BIT] = cal_busy;
        rdata_nxt[acs_pkg::ACS_ST_DONE_BIT] = done_r;
        rdata_nxt[acs_pkg::ACS_ST_HOLD_BIT] = hold_r;
        rdata_nxt[acs_pkg::ACS_ST_DSEL_BIT] = dsel_r;
        rdata_nxt[6:4] = state_r;
        rdata_nxt[acs_pkg::ACS_ST_SLEEP_BIT] = sleep_s;
      end else if (hit(avs_address, acs_pkg::ACS_OFF_CALCNT)) begin
        rdata_nxt[20:0] = cnt_r;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rtrim_r <= acs_pkg::ACS_CTRL_RTRIM_RST;
      swcal_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_r <= ack_nxt;
      rtrim_r <= rtrim_nxt;
      swcal_r <= swcal_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Conversion result pipeline
  acs_pipe_if #(.W(W)) pipe_bus ();
  assign pipe_bus.sample_in = adc_sample;
  assign adc_data_out = pipe_bus.sample_out;

  acs_sample_pipe #(.W(W), .DEPTH(acs_pkg::ACS_PIPE_LAT)) u_pipe (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .p(pipe_bus)
  );
endmodule

/* hw/acs_pkg.sv */
// Shared constants and types of the calibration sequencer
package acs_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] ACS_OFF_CTRL = 4'h0;
  localparam logic [3:0] ACS_OFF_STATUS = 4'h4;
  localparam logic [3:0] ACS_OFF_CALCNT = 4'h8;
  // Control field positions and values after reset
  localparam int ACS_CTRL_RTRIM_BIT = 0;
  localparam int ACS_CTRL_SWCAL_BIT = 1;
  localparam logic ACS_CTRL_RTRIM_RST = 1'b1;
  // Status field positions
  localparam int ACS_ST_BUSY_BIT = 0;
  localparam int ACS_ST_DONE_BIT = 1;
  localparam int ACS_ST_HOLD_BIT = 2;
  localparam int ACS_ST_DSEL_BIT = 3;
  localparam int ACS_ST_SLEEP_BIT = 7;
  // Calibrate pin phases, in sample clock cycles
  localparam logic [10:0] ACS_CAL_LOW_MIN = 11'h500;
  localparam logic [10:0] ACS_CAL_HIGH_MIN = 11'h500;
  // Start-up delays: 2^26 and 2^32 cycles
  localparam logic [32:0] ACS_DLY_SHORT = 33'h0_0400_0000;
  localparam logic [32:0] ACS_DLY_LONG = 33'h1_0000_0000;
  // Calibration lengths: typical 1.4e6 / 1.2e6, limits 1.62e6 / 1.35e6
  localparam logic [20:0] ACS_CAL_TRIM_TYP = 21'h15_5CC0;
  localparam logic [20:0] ACS_CAL_TRIM_MAX = 21'h18_B820;
  localparam logic [20:0] ACS_CAL_NOTRIM_TYP = 21'h12_4F80;
  localparam logic [20:0] ACS_CAL_NOTRIM_MAX = 21'h14_99F0;
  // Pipeline latency in sample clock cycles
  localparam int ACS_PIPE_LAT = 13;
  // Cycles the pin synchronisers need before straps are valid
  localparam logic [1:0] ACS_BOOT_CYC = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    ACS_S_BOOT = 3'b000,
    ACS_S_DELAY = 3'b001,
    ACS_S_HOLD = 3'b010,
    ACS_S_CAL = 3'b011,
    ACS_S_IDLE = 3'b100
  } acs_state_t;
endpackage

/* hw/acs_pipe_if.sv */
// Sample path between the sequencer core and the output pipeline
`timescale 1ns/1ns
interface acs_pipe_if #(parameter int W = 8);
  logic [W-1:0] sample_in;
  logic [W-1:0] sample_out;
  modport core (output sample_in, input sample_out);
  modport pipe (input sample_in, output sample_out);
endinterface

/* hw/acs_sample_pipe.sv */
// Fixed-latency sample pipeline, last stage on the falling edge
`timescale 1ns/1ns
module acs_sample_pipe #(
  parameter int W = 8,
  parameter int DEPTH = acs_pkg::ACS_PIPE_LAT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  acs_pipe_if.pipe p
);
  logic [W-1:0] stage_r [DEPTH];
  logic [W-1:0] stage_nxt [DEPTH];
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Shift one stage per rising edge
  always_comb begin
    stage_nxt[0] = p.sample_in;
    for (int i = 1; i < DEPTH; i++) begin
      stage_nxt[i] = stage_r[i-1];
    end
    out_nxt = stage_r[DEPTH-1];
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage_r[g] <= '0;
        end else if (clk_en) begin
          stage_r[g] <= stage_nxt[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output register updates on the falling edge
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      out_r <= '0;
    end else if (clk_en) begin
      out_r <= out_nxt;
    end
  end

  assign p.sample_out = out_r;
endmodule

/* sim/acs_cal_seq_assertions.sv */
// Port-level checks on the calibration sequencer
`timescale 1ns/1ns
module acs_cal_seq_checker #(
  parameter logic [32:0] DLY_SHORT_CYC = 33'h40,
  parameter logic [32:0] DLY_LONG_CYC = 33'h80,
  parameter logic [20:0] CAL_TRIM_CYC = 21'h30,
  parameter logic [20:0] CAL_NOTRIM_CYC = 21'h20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cal_pin,
  input wire logic sleep_request,
  input wire logic startup_delay_select,
  input wire logic [7:0] adc_sample,
  input wire logic [7:0] adc_data_out,
  input wire logic cal_busy,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  logic [33:0] up_cnt;
  logic [33:0] dly;
  logic [20:0] bcnt;
  logic first_r, pin_r, dsel_r, slp_r, zs_r;
  // Only enabled edges count, as in the design
  default clocking @(posedge clk iff clk_en); endclocking
  default disable iff (rst);
  // Delay expected from the captured strap
  assign dly = dsel_r ? {1'b0, DLY_LONG_CYC} : {1'b0, DLY_SHORT_CYC};
  ////////////////////////////////////////
  // Cycle counters and power-up captures
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 34'h0;
      bcnt <= 21'h0;
      first_r <= 1'b1;
      pin_r <= 1'b0;
      dsel_r <= 1'b0;
      slp_r <= 1'b0;
      zs_r <= 1'b0;
    end else if (clk_en) begin
      up_cnt <= up_cnt + 34'h1;
      bcnt <= cal_busy ? bcnt + 21'h1 : 21'h0;
      zs_r <= cal_busy && (zs_r || sleep_request);
      slp_r <= slp_r || sleep_request;
      first_r <= first_r && !cal_busy;
      pin_r <= (up_cnt == 34'h2) ? cal_pin : pin_r;
      dsel_r <= (up_cnt == 34'h2) ? startup_delay_select : dsel_r;
    end
  end
  ////////////////////////////////////////
  // Bus handshake steps, then calibration timing and pipeline checks
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_one_wait_state: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
    else $error("waitrequest not exactly one cycle");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_boot_quiet: assert property ($fell(rst) |-> !cal_busy [*8])
    else $error("busy right after reset");
  a_first_cal_time: assert property ($rose(cal_busy) && first_r && !pin_r |->
    up_cnt >= dly && (slp_r || up_cnt <= dly + 34'h10))
    else $error("power-up calibration start out of window");
  a_busy_length: assert property ($fell(cal_busy) && !zs_r |->
    bcnt == CAL_TRIM_CYC || bcnt == CAL_NOTRIM_CYC)
    else $error("calibration length wrong");
  a_busy_bound: assert property (cal_busy && !zs_r |-> bcnt < CAL_TRIM_CYC)
    else $error("calibration overruns");
  a_asleep_no_start: assert property (sleep_request [*6] |=> !$rose(cal_busy))
    else $error("calibration started asleep");
  a_pipe_latency: assert property (up_cnt > 34'h10 |-> adc_data_out == $past(adc_sample, 13))
    else $error("pipeline latency wrong");
endmodule
bind acs_cal_seq acs_cal_seq_checker #(.DLY_SHORT_CYC(DLY_SHORT_CYC), .DLY_LONG_CYC(DLY_LONG_CYC),
  .CAL_TRIM_CYC(CAL_TRIM_CYC), .CAL_NOTRIM_CYC(CAL_NOTRIM_CYC)) chk (.clk, .rst, .clk_en, .cal_pin,
  .sleep_request, .startup_delay_select, .adc_sample, .adc_data_out, .cal_busy, .avs_read,
  .avs_write, .avs_waitrequest);

/* sim/acs_ctrl_model.sv */
// External controller driving the calibrate and power-down pins
`timescale 1ns/1ns
module acs_ctrl_model (
  input wire logic clk,
  output logic cal_pin,
  output logic sleep_request
);
  // Pin levels at power-up
  initial begin
    cal_pin = 1'b0;
    sleep_request = 1'b0;
  end
  // Low phase then high phase, counted in clock cycles
  task automatic cal_pulse(input int lo, input int hi);
    @(posedge clk);
    cal_pin <= 1'b0;
    repeat (lo) @(posedge clk);
    cal_pin <= 1'b1;
    repeat (hi) @(posedge clk);
  endtask
  // Static pin levels, also used as power-up straps
  task automatic set_pins(input logic c, input logic s);
    @(posedge clk);
    cal_pin <= c;
    sleep_request <= s;
  endtask
endmodule

/* sim/acs_cal_seq_tb_top.sv */
// Testbench top for the calibration sequencer
`timescale 1ns/1ns
module acs_cal_seq_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_byteenable = 4'hF;
  logic startup_delay_select = 1'b0;
  logic [7:0] adc_sample = 8'h00;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [7:0] adc_data_out;
  logic cal_busy, avs_waitrequest, cal_pin, sleep_request;
  int checks = 0;
  int n_errors = 0;
  ////////////////////////////////////////
  // Clock and a sample that changes every cycle
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) adc_sample <= adc_sample + 8'h01;
  acs_ctrl_model ctl (.clk, .cal_pin, .sleep_request);
  acs_cal_seq #(.DLY_SHORT_CYC(33'h40), .DLY_LONG_CYC(33'h80), .CAL_TRIM_CYC(21'h30),
    .CAL_NOTRIM_CYC(21'h20)) uut (.clk, .rst, .clk_en, .cal_pin, .sleep_request,
    .startup_delay_select, .adc_sample, .adc_data_out, .cal_busy, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  ////////////////////////////////////////
  // Compare, bus and wait helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Hold the request until an edge samples waitrequest low
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      @(posedge clk);
    end
    check(32'(n), 32'h1);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (cal_busy !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(32'(cal_busy), 32'(v));
  endtask
  task automatic do_reset(input logic c, input logic s, input logic d);
    @(posedge clk);
    rst <= 1'b1;
    startup_delay_select <= d;
    ctl.set_pins(c, s);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic pipe_check();
    logic [7:0] e;
    @(posedge clk);
    e = adc_sample - 8'h0D;
    check(32'(adc_data_out), 32'(e));
    #2;
    check(32'(adc_data_out), 32'(e));
    @(negedge clk);
    #2;
    check(32'(adc_data_out), 32'(e + 8'h01));
  endtask
  task automatic finish_test();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    do_reset(1'b0, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    rd(acs_pkg::ACS_OFF_STATUS, 32'h90);
    ctl.set_pins(1'b0, 1'b0);
    repeat (40) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 100);
    rd(acs_pkg::ACS_OFF_STATUS, 32'h42);
    rd(acs_pkg::ACS_OFF_CTRL, 32'h1);
    rd(4'hC, 32'h0);
    pipe_check();
    wr(acs_pkg::ACS_OFF_CTRL, 32'h2);
    wait_busy(1'b1, 20);
    wr(acs_pkg::ACS_OFF_CTRL, 32'h2);
    wait_busy(1'b0, 60);
    repeat (20) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    // Byte lane 0 off: control write dropped
    @(posedge clk);
    avs_byteenable <= 4'hE;
    wr(acs_pkg::ACS_OFF_CTRL, 32'h3);
    avs_byteenable <= 4'hF;
    rd(acs_pkg::ACS_OFF_CTRL, 32'h0);
    check(32'(cal_busy), 32'h0);
    // Clock enable low freezes a running calibration
    wr(acs_pkg::ACS_OFF_CTRL, 32'h2);
    wait_busy(1'b1, 20);
    clk_en <= 1'b0;
    repeat (100) @(posedge clk);
    check(32'(cal_busy), 32'h1);
    clk_en <= 1'b1;
    wait_busy(1'b0, 60);
    ctl.cal_pulse(1280, 1280);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 60);
    rd(acs_pkg::ACS_OFF_CALCNT, 32'h20);
    ctl.cal_pulse(1279, 1280);
    repeat (10) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    ctl.cal_pulse(1280, 1278);
    ctl.set_pins(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    ctl.set_pins(1'b1, 1'b1);
    repeat (10) @(posedge clk);
    wr(acs_pkg::ACS_OFF_CTRL, 32'h2);
    repeat (10) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    do_reset(1'b0, 1'b0, 1'b1);
    repeat (100) @(posedge clk);
    check(32'(cal_busy), 32'h0);
    rd(acs_pkg::ACS_OFF_STATUS, 32'h18);
    wait_busy(1'b1, 70);
    do_reset(1'b1, 1'b0, 1'b0);
    repeat (200) @(posedge clk);
    rd(acs_pkg::ACS_OFF_STATUS, 32'h24);
    ctl.cal_pulse(1280, 1280);
    wait_busy(1'b1, 20);
    finish_test();
  end
endmodule
